// ### sfp_sync_filter_power_control.sv
// line/frame sync conditioning, output sync timing and power-down control
`timescale 1ns/10ps
`default_nettype none
module sfp_sync_filter_power_control
    import sfp_pkg::*;
#(
    parameter int DATA_W          = 30,
    parameter int ACT_TIMEOUT_CYC = ACT_TIMEOUT_DEF
) (
    input  wire logic               clk_in,
    input  wire logic               rst_in,
    input  wire logic               reg_write_in,
    input  wire logic [7:0]         reg_addr_in,
    input  wire logic [7:0]         reg_wdata_in,
    output logic      [7:0]         reg_rdata_out,
    input  wire logic [1:0]         line_sync_inputs_in,
    input  wire logic [1:0]         green_sync_inputs_in,
    input  wire logic               frame_sync_in,
    input  wire logic               power_down_pin_in,
    input  wire logic [DATA_W-1:0]  data_in,
    output logic                    pll_sync_out,
    output logic                    regen_line_sync_out,
    output logic                    frame_sync_out,
    output logic                    odd_field_out,
    output logic                    line_sync_output_out,
    output logic                    output_data_clock_out,
    output logic      [DATA_W-1:0]  data_out,
    output logic                    data_valid_out,
    output logic                    outputs_oe_n_out,
    output logic                    green_sync_output_out,
    output logic                    green_sync_output_oe_n_out,
    output logic                    powered_down_out,
    output logic      [PHASE_W-1:0] sampling_phase_out
);
    localparam int ACT_W = $clog2(ACT_TIMEOUT_CYC + 1);

    logic [5:0]        pins_sync;
    logic [7:0]        hs_pol_reg, hs_width_reg, fs_ctrl_reg, phase_reg;
    logic [7:0]        power_reg, src_reg, window_reg;
    logic              pol_high_reg, raw_act_d_reg;
    logic [LINE_W-1:0] line_cnt_reg, period_reg, high_cnt_reg;
    logic [7:0]        regen_hold_reg;
    logic              filt_reg, extra_line_reg, extra_stat_reg;
    logic              proc_d_reg, proc_pend_reg;
    logic              seen_reg, subst_reg;
    logic [7:0]        hs_cnt_reg;
    logic [3:0]        fs_cnt_reg;
    logic              pd_reg;
    logic [2:0]        valid_cnt_reg;
    logic [DATA_W-1:0] pipe_reg [INVALID_SETS];
    logic [3:0]        act_det;
    logic [3:0]        act_d_reg;

    sfp_sync2 #(
        .W (6)
    ) u_pin_sync (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .async_in ({frame_sync_in, power_down_pin_in, green_sync_inputs_in, line_sync_inputs_in}),
        .sync_out (pins_sync)
    );

    // register write decode
    wire wr_en  = reg_write_in;
    wire wr_pol = wr_en && (reg_addr_in == ADDR_HS_POL);
    wire wr_wid = wr_en && (reg_addr_in == ADDR_HS_WIDTH);
    wire wr_fs  = wr_en && (reg_addr_in == ADDR_FS_CTRL);
    wire wr_ph  = wr_en && (reg_addr_in == ADDR_PHASE);
    wire wr_pwr = wr_en && (reg_addr_in == ADDR_POWER);
    wire wr_src = wr_en && (reg_addr_in == ADDR_SRC_SEL);
    wire wr_win = wr_en && (reg_addr_in == ADDR_WINDOW);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            hs_pol_reg   <= RST_HS_POL;
            hs_width_reg <= RST_HS_WIDTH;
            fs_ctrl_reg  <= RST_FS_CTRL;
            phase_reg    <= RST_PHASE;
            power_reg    <= RST_POWER;
            src_reg      <= RST_SRC_SEL;
            window_reg   <= RST_WINDOW;
        end else begin
            if (wr_pol) hs_pol_reg <= reg_wdata_in;
            if (wr_wid) hs_width_reg <= reg_wdata_in;
            if (wr_fs) fs_ctrl_reg <= reg_wdata_in;
            if (wr_ph) phase_reg <= reg_wdata_in;
            if (wr_pwr) power_reg <= reg_wdata_in;
            if (wr_src) src_reg <= reg_wdata_in;
            if (wr_win) window_reg <= reg_wdata_in;
        end
    end

    // sync activity detectors, one per line and green sync input
    wire [3:0] act_src = {pins_sync[0], pins_sync[1], pins_sync[2], pins_sync[3]};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_act
            logic [ACT_W-1:0] act_cnt_reg;
            always_ff @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    act_cnt_reg <= '0;
                end else if (act_src[gi] != act_d_reg[gi]) begin
                    act_cnt_reg <= ACT_W'(ACT_TIMEOUT_CYC);
                end else if (act_cnt_reg != '0) begin
                    act_cnt_reg <= act_cnt_reg - 1'b1;
                end
            end
            assign act_det[gi] = (act_cnt_reg != '0);
        end
    endgenerate

    // detect byte: line0, line1, green0, green1
    wire [7:0] detect_byte = {act_det[3], act_det[2], 2'b00, act_det[1], act_det[0], 2'b00};
    wire sync_activity = detect_byte[DET_LINE0_BIT] | detect_byte[DET_LINE1_BIT]
                       | detect_byte[DET_GREEN0_BIT] | detect_byte[DET_GREEN1_BIT];

    // pin polarity then OR software bit
    wire pin_pd    = power_reg[PWR_PINPOL_BIT] ? pins_sync[4] : ~pins_sync[4];
    wire manual_pd = pin_pd | power_reg[PWR_SW_BIT];
    wire pd_next   = power_reg[PWR_AUTO_BIT] ? ~sync_activity : manual_pd;

    // raw sync selection and polarity normalisation
    wire line_sel  = src_reg[SRC_INPUT_BIT] ? pins_sync[1] : pins_sync[0];
    wire green_sel = src_reg[SRC_INPUT_BIT] ? pins_sync[3] : pins_sync[2];
    wire raw_sel   = src_reg[SRC_GREEN_BIT] ? green_sel : line_sel;
    wire raw_act   = raw_sel ~^ pol_high_reg;
    wire raw_rise  = raw_act & ~raw_act_d_reg;

    // regenerator prediction limits
    wire [LINE_W:0] early_lim = {1'b0, period_reg} - {3'b000, period_reg[LINE_W-1:2]};
    wire [LINE_W:0] late_lim  = {1'b0, period_reg} + {3'b000, period_reg[LINE_W-1:2]};
    wire            have_per  = (period_reg != '0);
    // early edges ignored, missing edges substituted
    wire accept     = raw_rise && (!have_per || ({1'b0, line_cnt_reg} >= early_lim));
    wire missing    = have_per && !accept && ({1'b0, line_cnt_reg} >= late_lim);
    wire regen_edge = accept | missing;
    // period only trusted between two real edges with no substitute between them
    wire learn      = accept && seen_reg && !subst_reg;

    // window half-width in ns around the regenerated edge
    wire [TIME_W-1:0] win_ns    = TIME_W'(window_reg) * WIN_UNIT_NS;
    wire [TIME_W-1:0] since_ns  = TIME_W'(line_cnt_reg) * CLK_PERIOD_NS;
    // distance to the predicted edge, early or late side
    wire [LINE_W-1:0] to_go     = (line_cnt_reg <= period_reg) ? period_reg - line_cnt_reg
                                                               : line_cnt_reg - period_reg;
    wire [TIME_W-1:0] to_go_ns  = TIME_W'(to_go) * CLK_PERIOD_NS;
    wire              in_window = !have_per || (since_ns <= win_ns) || (to_go_ns <= win_ns);
    // edges inside window pass, outside are discarded
    wire filt_edge  = raw_rise && in_window;
    wire outside    = raw_rise && !in_window;

    wire regen_lvl  = (regen_hold_reg != 8'h00);
    wire proc_sync  = src_reg[SRC_REGEN_BIT] ? regen_lvl : raw_act;
    wire proc_rise  = proc_sync & ~proc_d_reg;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pol_high_reg   <= 1'b1;
            raw_act_d_reg  <= 1'b0;
            line_cnt_reg   <= '0;
            period_reg     <= '0;
            high_cnt_reg   <= '0;
            regen_hold_reg <= 8'h00;
            filt_reg       <= 1'b0;
            extra_line_reg <= 1'b0;
            extra_stat_reg <= 1'b0;
            proc_d_reg     <= 1'b0;
            act_d_reg      <= 4'h0;
            seen_reg       <= 1'b0;
            subst_reg      <= 1'b0;
        end else begin
            raw_act_d_reg <= raw_act;
            proc_d_reg    <= proc_sync;
            act_d_reg     <= act_src;
            if (regen_edge) begin
                line_cnt_reg   <= '0;
                regen_hold_reg <= REGEN_WIDTH_CYC;
                if (learn) begin
                    period_reg <= line_cnt_reg;
                end
            end else begin
                if (line_cnt_reg != '1) line_cnt_reg <= line_cnt_reg + 1'b1;
                if (regen_lvl) regen_hold_reg <= regen_hold_reg - 1'b1;
            end
            if (accept) begin
                seen_reg  <= 1'b1;
                subst_reg <= 1'b0;
            end else if (missing) begin
                subst_reg <= 1'b1;
            end
            // input polarity from high time per line
            if (accept) begin
                if (learn) pol_high_reg <= (high_cnt_reg < {1'b0, line_cnt_reg[LINE_W-1:1]});
                high_cnt_reg <= '0;
            end else if (raw_sel && high_cnt_reg != '1) begin
                high_cnt_reg <= high_cnt_reg + 1'b1;
            end
            // filtered level starts at in-window edge
            if (filt_edge) filt_reg <= 1'b1;
            else if (!raw_act) filt_reg <= 1'b0;
            // extraneous status refreshed each line, set wins
            if (regen_edge) begin
                extra_stat_reg <= extra_line_reg | outside;
                extra_line_reg <= outside;
            end else if (outside) begin
                extra_line_reg <= 1'b1;
            end
        end
    end

    // frame filter: minimum duration, line-edge avoidance, field
    wire fs_raw     = pins_sync[5];
    wire fs_en      = fs_ctrl_reg[FS_EN_BIT];
    wire fs_long    = (fs_cnt_reg >= FRAME_MIN_CYC);
    wire fs_set     = fs_en ? (fs_long && !proc_rise) : fs_raw;
    wire fs_start   = fs_raw && fs_set && !frame_sync_out;

    // data clock: data changes when the clock falls
    wire pix_tick   = output_data_clock_out;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            fs_cnt_reg     <= 4'h0;
            frame_sync_out <= 1'b0;
            odd_field_out  <= 1'b0;
        end else begin
            if (!fs_raw) fs_cnt_reg <= 4'h0;
            else if (!fs_long) fs_cnt_reg <= fs_cnt_reg + 1'b1;
            if (!fs_raw) frame_sync_out <= 1'b0;
            else if (fs_set) frame_sync_out <= 1'b1;
            if (fs_start) begin
                odd_field_out <= (line_cnt_reg >= {1'b0, period_reg[LINE_W-1:1]});
            end
        end
    end

    // line sync output timing on the pixel tick
    wire [7:0] hs_cnt_next = (proc_pend_reg || proc_rise) ? hs_width_reg
                           : ((hs_cnt_reg != 8'h00) ? hs_cnt_reg - 1'b1 : 8'h00);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pd_reg                <= 1'b0;
            proc_pend_reg         <= 1'b0;
            hs_cnt_reg            <= 8'h00;
            line_sync_output_out  <= 1'b0;
            output_data_clock_out <= 1'b0;
            valid_cnt_reg         <= 3'h0;
            data_valid_out        <= 1'b0;
        end else begin
            pd_reg <= pd_next;
            // clock toggles; data moves on its falling edge
            output_data_clock_out <= !pd_reg && !output_data_clock_out;
            if (pd_reg) begin
                proc_pend_reg  <= 1'b0;
                hs_cnt_reg     <= 8'h00;
                valid_cnt_reg  <= 3'h0;
                data_valid_out <= 1'b0;
            end else if (pix_tick) begin
                proc_pend_reg <= 1'b0;
                hs_cnt_reg    <= hs_cnt_next;
                // polarity applied, aligned to data update
                line_sync_output_out <= (hs_cnt_next != 8'h00) ~^ hs_pol_reg[HSPOL_BIT];
                if (valid_cnt_reg != INVALID_SETS) valid_cnt_reg <= valid_cnt_reg + 1'b1;
                data_valid_out <= (valid_cnt_reg >= INVALID_SETS - 3'h1);
            end else if (proc_rise) begin
                proc_pend_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < INVALID_SETS; i++) begin
                pipe_reg[i] <= '0;
            end
            data_out <= '0;
        end else if (pix_tick && !pd_reg) begin
            pipe_reg[0] <= data_in;
            for (int i = 1; i < INVALID_SETS; i++) begin
                pipe_reg[i] <= pipe_reg[i-1];
            end
            data_out <= pipe_reg[INVALID_SETS-1];
        end
    end

    // read mux
    logic [7:0] rd_mux;
    always_comb begin
        unique case (reg_addr_in)
            ADDR_HS_POL:    rd_mux = hs_pol_reg;
            ADDR_HS_WIDTH:  rd_mux = hs_width_reg;
            ADDR_FS_CTRL:   rd_mux = fs_ctrl_reg;
            ADDR_PHASE:     rd_mux = phase_reg;
            ADDR_POWER:     rd_mux = power_reg;
            ADDR_SRC_SEL:   rd_mux = src_reg;
            ADDR_WINDOW:    rd_mux = window_reg;
            ADDR_DETECT:    rd_mux = detect_byte;
            ADDR_FILT_STAT: rd_mux = {6'h00, extra_stat_reg, 1'b0};
            default:        rd_mux = 8'h00;
        endcase
    end

    wire pll_next = src_reg[SRC_PLL_FILT_BIT] ? filt_reg : raw_act;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            reg_rdata_out              <= 8'h00;
            pll_sync_out               <= 1'b0;
            regen_line_sync_out        <= 1'b0;
            outputs_oe_n_out           <= 1'b1;
            green_sync_output_out      <= 1'b0;
            green_sync_output_oe_n_out <= 1'b1;
            powered_down_out           <= 1'b0;
            sampling_phase_out         <= '0;
        end else begin
            reg_rdata_out       <= rd_mux;
            pll_sync_out        <= pll_next;
            regen_line_sync_out <= regen_lvl;
            // outputs float when powered down or on request
            outputs_oe_n_out    <= pd_reg | power_reg[PWR_OUT_HIZ_BIT];
            // green sync output runs regardless of power-down
            green_sync_output_out      <= green_sel;
            // green sync output high impedance bit
            green_sync_output_oe_n_out <= power_reg[PWR_GSO_HIZ_BIT];
            powered_down_out    <= pd_reg;
            sampling_phase_out  <= phase_reg[PHASE_W-1:0];
        end
    end
endmodule : sfp_sync_filter_power_control
`default_nettype wire

// ### sfp_pkg.sv
// constants shared by the sync filter and power control block
package sfp_pkg;
    // register addresses
    localparam logic [7:0] ADDR_HS_POL      = 8'h12;
    localparam logic [7:0] ADDR_HS_WIDTH    = 8'h13;
    localparam logic [7:0] ADDR_FS_CTRL     = 8'h14;
    localparam logic [7:0] ADDR_PHASE       = 8'h19;
    localparam logic [7:0] ADDR_POWER       = 8'h1e;
    localparam logic [7:0] ADDR_SRC_SEL     = 8'h20;
    localparam logic [7:0] ADDR_WINDOW      = 8'h23;
    localparam logic [7:0] ADDR_DETECT      = 8'h24;
    localparam logic [7:0] ADDR_FILT_STAT   = 8'h25;
    // field positions
    localparam int HSPOL_BIT        = 3;
    localparam int FS_EN_BIT        = 2;
    localparam int PWR_AUTO_BIT     = 4;
    localparam int PWR_SW_BIT       = 3;
    localparam int PWR_PINPOL_BIT   = 2;
    localparam int PWR_OUT_HIZ_BIT  = 1;
    localparam int PWR_GSO_HIZ_BIT  = 0;
    localparam int SRC_GREEN_BIT    = 3;
    localparam int SRC_PLL_FILT_BIT = 2;
    localparam int SRC_REGEN_BIT    = 1;
    localparam int SRC_INPUT_BIT    = 0;
    localparam int DET_LINE0_BIT    = 7;
    localparam int DET_LINE1_BIT    = 6;
    localparam int DET_GREEN0_BIT   = 3;
    localparam int DET_GREEN1_BIT   = 2;
    localparam int FILT_EXTRA_BIT   = 1;
    localparam int PHASE_W          = 5;
    // values after reset
    localparam logic [7:0] RST_HS_POL     = 8'h08;
    localparam logic [7:0] RST_HS_WIDTH   = 8'h20;
    localparam logic [7:0] RST_FS_CTRL    = 8'h04;
    localparam logic [7:0] RST_PHASE      = 8'h00;
    localparam logic [7:0] RST_POWER      = 8'h04;
    localparam logic [7:0] RST_SRC_SEL    = 8'h06;
    localparam logic [7:0] RST_WINDOW     = 8'h0a;
    // timing
    localparam int LINE_W = 16;
    localparam int TIME_W = 20;
    localparam logic [TIME_W-1:0] CLK_PERIOD_NS = 20'h0000a;
    localparam logic [TIME_W-1:0] WIN_UNIT_NS   = 20'h00019;
    localparam logic [7:0] REGEN_WIDTH_CYC = 8'h10;
    localparam logic [3:0] FRAME_MIN_CYC   = 4'h4;
    localparam logic [2:0] INVALID_SETS    = 3'h6;
    localparam int ACT_TIMEOUT_DEF = 65536;
endpackage : sfp_pkg

// ### sfp_sync2.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
`default_nettype none
module sfp_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : sfp_sync2
`default_nettype wire

// ### sfp_sync_filter_power_control_assertions.sv
// checker: port-level properties of the sync filter and power control block
`timescale 1ns/10ps
`default_nettype none
module sfp_sync_filter_power_control_assertions
    import sfp_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       reg_write_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic [7:0] reg_rdata_out,
    input  wire logic       regen_line_sync_out,
    input  wire logic       output_data_clock_out,
    input  wire logic       data_valid_out,
    input  wire logic       outputs_oe_n_out,
    input  wire logic       green_sync_output_oe_n_out,
    input  wire logic       powered_down_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    logic [2:0] ticks_reg;
    logic [2:0] ticks_next;
    // pixel ticks seen since power-up while data is not yet valid
    assign ticks_next = (powered_down_out || data_valid_out) ? 3'h0 :
                        (output_data_clock_out && ticks_reg != 3'h7) ? ticks_reg + 3'h1 : ticks_reg;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ticks_reg <= 3'h0;
        end else begin
            ticks_reg <= ticks_next;
        end
    end
    width_readback_a: assert property (
        (reg_write_in && reg_addr_in == ADDR_HS_WIDTH) ##1 (!reg_write_in && reg_addr_in == ADDR_HS_WIDTH)
        |=> reg_rdata_out == $past(reg_wdata_in, 2)) else $error("width readback differs from write");
    unmapped_zero_a: assert property (
        reg_addr_in == 8'h00 |=> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
    green_hiz_a: assert property (
        (reg_write_in && reg_addr_in == ADDR_POWER)
        |-> ##2 green_sync_output_oe_n_out == $past(reg_wdata_in[PWR_GSO_HIZ_BIT], 2))
        else $error("green output enable does not follow its bit");
    outputs_hiz_a: assert property (
        (reg_write_in && reg_addr_in == ADDR_POWER && reg_wdata_in[PWR_OUT_HIZ_BIT])
        |-> ##[2:3] outputs_oe_n_out) else $error("outputs not floated");
    soft_powerdown_a: assert property (
        (reg_write_in && reg_addr_in == ADDR_POWER && !reg_wdata_in[PWR_AUTO_BIT] && reg_wdata_in[PWR_SW_BIT])
        |-> ##[1:4] powered_down_out) else $error("software power-down ignored");
    clock_half_rate_a: assert property (
        !powered_down_out [*4] |-> output_data_clock_out != $past(output_data_clock_out))
        else $error("data clock not at half rate");
    powerdown_quiet_a: assert property (
        powered_down_out [*2] |-> !output_data_clock_out && !data_valid_out)
        else $error("clock or valid active while powered down");
    regen_pulse_a: assert property (
        $rose(regen_line_sync_out) |-> regen_line_sync_out [*8] ##1 regen_line_sync_out [*8]
        ##1 !regen_line_sync_out) else $error("regenerated pulse not 16 cycles");
    valid_sixth_a: assert property (
        $rose(data_valid_out) |-> ticks_reg inside {3'h5, 3'h6}) else $error("valid not at sixth tick");
endmodule : sfp_sync_filter_power_control_assertions
bind sfp_sync_filter_power_control sfp_sync_filter_power_control_assertions u_chk (
    .clk_in(clk_in), .rst_in(rst_in), .reg_write_in(reg_write_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .regen_line_sync_out(regen_line_sync_out),
    .output_data_clock_out(output_data_clock_out), .data_valid_out(data_valid_out),
    .outputs_oe_n_out(outputs_oe_n_out), .green_sync_output_oe_n_out(green_sync_output_oe_n_out),
    .powered_down_out(powered_down_out));
`default_nettype wire

// ### sfp_display_model.sv
// display controller model: captures line sync on the rising data clock
`timescale 1ns/10ps
`default_nettype none
module sfp_display_model (
    input  wire logic       rst_in,
    input  wire logic       data_clock_in,
    input  wire logic       line_sync_in,
    input  wire logic       active_high_in,
    output logic      [7:0] hs_width_out
);
    logic [2:0] skip_reg;
    logic [7:0] run_reg;
    logic       hs_act;
    assign hs_act = (line_sync_in == active_high_in);
    always_ff @(posedge data_clock_in or posedge rst_in) begin
        if (rst_in) begin
            skip_reg     <= 3'h0;
            run_reg      <= 8'h00;
            hs_width_out <= 8'h00;
        end else if (skip_reg != 3'h6) begin
            skip_reg <= skip_reg + 3'h1;
        end else if (hs_act) begin
            run_reg <= run_reg + 8'h1;
        end else if (run_reg != 8'h00) begin
            hs_width_out <= run_reg;
            run_reg      <= 8'h00;
        end
    end
endmodule : sfp_display_model
`default_nettype wire

// ### sfp_sync_filter_power_control_test.sv
// testbench: register, sync, frame and power scenarios
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, (a), (e)); end end
module sfp_sync_filter_power_control_test
    import sfp_pkg::*;
;
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        wr = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic [1:0]  ls = 2'h0;
    logic [1:0]  gs = 2'h0;
    logic        fs = 1'b0;
    logic        pin = 1'b0;
    logic        hs_hi = 1'b1;
    logic        hit;
    logic        odd;
    logic [29:0] dat = 30'h0;
    logic [29:0] dout;
    logic [7:0]  rdata, mw;
    logic [4:0]  phase;
    logic        pll, regen, fso, hso, dck, dv, oe_n, gso, gso_oe_n, pd;
    int          mismatches = 0;
    int          cmp_count = 0;
    logic [7:0]  ra [7] = '{ADDR_HS_POL, ADDR_HS_WIDTH, ADDR_FS_CTRL, ADDR_PHASE, ADDR_POWER, ADDR_SRC_SEL, ADDR_WINDOW};
    logic [7:0]  rv [7] = '{RST_HS_POL, RST_HS_WIDTH, RST_FS_CTRL, RST_PHASE, RST_POWER, RST_SRC_SEL, RST_WINDOW};
    always #5 clk_in = ~clk_in;
    always @(negedge clk_in) dat <= dat + 30'h1;
    sfp_sync_filter_power_control #(.ACT_TIMEOUT_CYC(256)) uut (
        .clk_in(clk_in), .rst_in(rst_in), .reg_write_in(wr), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_rdata_out(rdata), .line_sync_inputs_in(ls), .green_sync_inputs_in(gs), .frame_sync_in(fs),
        .power_down_pin_in(pin), .data_in(dat), .pll_sync_out(pll), .regen_line_sync_out(regen),
        .frame_sync_out(fso), .odd_field_out(odd), .line_sync_output_out(hso), .output_data_clock_out(dck),
        .data_out(dout), .data_valid_out(dv), .outputs_oe_n_out(oe_n), .green_sync_output_out(gso),
        .green_sync_output_oe_n_out(gso_oe_n), .powered_down_out(pd), .sampling_phase_out(phase));
    sfp_display_model u_disp (.rst_in(rst_in), .data_clock_in(dck), .line_sync_in(hso),
        .active_high_in(hs_hi), .hs_width_out(mw));
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask : cyc
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk_in);
        wr = 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_in);
        addr = a;
        @(negedge clk_in);
        `CHK(rdata, e)
    endtask : rd_chk
    // 200-cycle lines; optional stray pulse mid-line, pll sync watched meanwhile
    task automatic lines(input int n, input logic extra);
        hit = 1'b0;
        repeat (n) begin
            ls[0] = 1'b1;
            cyc(20);
            ls[0] = 1'b0;
            cyc(80);
            ls[0] = extra;
            repeat (10) begin
                @(negedge clk_in);
                hit = hit | pll;
            end
            ls[0] = 1'b0;
            cyc(90);
        end
    endtask : lines
    task automatic frame(input int n, input logic e);
        hit = 1'b0;
        for (int i = 0; i < n + 8; i++) begin
            fs = (i < n);
            @(negedge clk_in);
            hit = hit | fso;
        end
        `CHK(hit, e)
    endtask : frame
    task automatic wait_pd(input logic v);
        int i;
        for (i = 0; i < 400 && pd !== v; i++) @(negedge clk_in);
        `CHK(pd, v)
        if (i == 400) tally_and_finish();
    endtask : wait_pd
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    initial begin
        cyc(5);
        rst_in = 1'b0;
        for (int i = 0; i < 7; i++) rd_chk(ra[i], rv[i]);
        wr_reg(ADDR_DETECT, 8'hff);
        rd_chk(ADDR_DETECT, 8'h00);
        rd_chk(8'h00, 8'h00);
        wr_reg(ADDR_HS_WIDTH, 8'h03);
        rd_chk(ADDR_HS_WIDTH, 8'h03);
        wr_reg(ADDR_PHASE, 8'h1f);
        cyc(1);
        `CHK(phase, 5'h1f)
        $display("test registers done");
        lines(6, 1'b0);
        `CHK(mw, 8'h03)
        rd_chk(ADDR_DETECT, 8'h80);
        `CHK(dv, 1'b1)
        `CHK((dat - dout) >> 1, 30'(INVALID_SETS))
        lines(2, 1'b1);
        `CHK(hit, 1'b0)
        lines(1, 1'b0);
        rd_chk(ADDR_FILT_STAT, 8'h02);
        lines(2, 1'b0);
        rd_chk(ADDR_FILT_STAT, 8'h00);
        wr_reg(ADDR_SRC_SEL, 8'h02);
        lines(1, 1'b1);
        `CHK(hit, 1'b1)
        wr_reg(ADDR_SRC_SEL, RST_SRC_SEL);
        wr_reg(ADDR_HS_POL, 8'h00);
        hs_hi = 1'b0;
        lines(3, 1'b0);
        `CHK(mw, 8'h03)
        `CHK(hso, 1'b1)
        $display("test line sync done");
        wr_reg(ADDR_FS_CTRL, 8'h04);
        frame(12, 1'b1);
        `CHK(odd, 1'b1)
        frame(2, 1'b0);
        $display("test frame sync done");
        wr_reg(ADDR_POWER, 8'h06);
        cyc(3);
        `CHK(oe_n, 1'b1)
        `CHK(pd, 1'b0)
        wr_reg(ADDR_POWER, 8'h05);
        cyc(3);
        `CHK(gso_oe_n, 1'b1)
        `CHK(oe_n, 1'b0)
        wr_reg(ADDR_POWER, 8'h0c);
        wait_pd(1'b1);
        `CHK(dv, 1'b0)
        wr_reg(ADDR_POWER, 8'h04);
        wait_pd(1'b0);
        pin = 1'b1;
        wait_pd(1'b1);
        wr_reg(ADDR_POWER, 8'h00);
        wait_pd(1'b0);
        pin = 1'b0;
        wait_pd(1'b1);
        wr_reg(ADDR_POWER, 8'h14);
        cyc(3);
        wait_pd(1'b1);
        gs[0] = 1'b1;
        cyc(4);
        `CHK(gso, 1'b1)
        wait_pd(1'b0);
        $display("test power done");
        tally_and_finish();
    end
endmodule : sfp_sync_filter_power_control_test
`default_nettype wire
